// *** verilog/gas_gauge_control_sequencer.sv ***
// Control register, status flags, charge prescaler/accumulator, alert or
// charge-complete pin handling and the conversion sequencer of a charge gauge.
// Assumes a two-wire protocol engine on the same clock delivering register
// strobes and an alert-response completion pulse; the pin is asynchronous.
// Operation
// - Shutdown bit set powers down analog section; registers keep their contents.
// - Register access keeps working while shut down.
// - No charge counted in shutdown; fraction below one count dropped on entry.
// - Pin config 10 (default): active-low alert on threshold cross or wrap.
// - Asserted alert released only by a completed alert response from master.
// - Changing pin config keeps a pending alert low until alert response.
// - Pin config 01: pin is input; low level forces accumulator to FFFFh.
// - Pin config 00: pin not sensed and driven only by an alert still pending; board pulls it up.
// - Prescaler M is two to the power twice the code; default 4096.
// - Prescaler codes above 6 are limited to 4096.
// - One accumulator count equals M integrator steps.
// - ADC mode resets to 00: converter asleep.
// - Mode 01 runs one voltage, current, temperature pass then clears to 00.
// - Mode 10 converts all three, sleeps ten seconds, repeats.
// - Mode 11 repeats passes back to back with no sleep.
// - Mode changes mid-pass take effect only after the pass completes.
// - Voltage conversion takes 33 ms, current and temperature 4.5 ms each.
// - Result is stored at each conversion end before the next starts.
// - Out-of-range result sets its flag and asserts alert in alert mode.
// - Status flags clear on status read and may set again later.
// - Accumulator wraps on overflow or underflow and sets the wrap flag.
// - Status bits: current 6, wrap 5, temp 4, high 3, low 2, volt 1, undervoltage_lockout 0.
`timescale 1ns/1ps

module gas_gauge_control_sequencer
   import gauge_pkg::*;
#(
   parameter int VOLT_CONV_CYCLES_P = VOLT_CONV_CYCLES,
   parameter int AUX_CONV_CYCLES_P = AUX_CONV_CYCLES,
   parameter int SCAN_SLEEP_CYCLES_P = SCAN_SLEEP_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ctrlWrite,
   input wire logic [7:0] ctrlWriteData,
   output logic [7:0] control,
   input wire logic statusRead,
   output logic [7:0] status,
   input wire logic accWrite,
   input wire logic [15:0] accWriteData,
   output logic [15:0] chargeAcc,
   input wire logic [15:0] chargeThreshHigh,
   input wire logic [15:0] chargeThreshLow,
   input wire logic chargeUpTick,
   input wire logic chargeDownTick,
   input wire logic undervoltageLockout,
   input wire logic alertResponseDone,
   input wire logic convOutOfRange,
   output logic adcBusy,
   output logic [1:0] adcChannel,
   output logic resultStore,
   output logic analogEnable,
   input wire logic pinIn,
   output logic pinOut,
   output logic pinOe
);

   logic shutdown;
   pin_cfg_t pinCfg;
   logic [2:0] prescCode;
   adc_mode_t adcMode;
   logic [3:0] prescShift;
   logic [11:0] prescMax;
   logic [11:0] prescCount;
   logic shutdownDly;
   logic pinMeta;
   logic pinSync;
   logic fullRequest;
   seq_t seqState;
   logic [31:0] seqCount;
   logic [31:0] seqLimit;
   logic convEnd;
   logic passEnd;
   logic [15:0] next_acc;
   logic accStep;
   logic accWrap;
   logic [7:0] statusSet;
   logic alertEvent;
   logic modeClear;

   assign shutdown = control[SHUTDOWN_BIT];
   assign pinCfg = pin_cfg_t'(control[PIN_CFG_LSB +: 2]);
   assign prescCode = control[PRESC_LSB +: 3];
   assign adcMode = adc_mode_t'(control[ADC_MODE_LSB +: 2]);

   // Factor M as a modulo limit; codes past the top one clamp to 4096
   always_comb begin
      prescShift = (prescCode > PRESC_CODE_MAX) ? {PRESC_CODE_MAX, 1'b0} : {prescCode, 1'b0};
      prescMax = 12'((13'h1 << prescShift) - 13'h1);
   end

   // Control register; host writes win over the self-clearing of manual mode
   always_ff @(posedge clk) begin
      if (srst) begin
         control <= CONTROL_RESET;
      end else if (ctrlWrite) begin
         control <= ctrlWriteData;
      end else if (modeClear) begin
         control[ADC_MODE_LSB +: 2] <= ADC_SLEEP;
      end
   end

   // Analog power follows the shutdown bit; register state is untouched
   always_ff @(posedge clk) begin
      if (srst) begin
         analogEnable <= 1'b0;
         shutdownDly <= 1'b0;
      end else begin
         analogEnable <= ~shutdown;
         shutdownDly <= shutdown;
      end
   end

   // Two-stage synchroniser on the pin; only the second stage is used
   always_ff @(posedge clk) begin
      if (srst) begin
         pinMeta <= 1'b1;
         pinSync <= 1'b1;
      end else begin
         pinMeta <= pinIn;
         pinSync <= pinMeta;
      end
   end

   // The pin is sensed only in charge-complete mode
   assign fullRequest = (pinCfg == PIN_FULL_IN) && !pinSync;

   // Prescaler: M integrator steps make one accumulator count
   always_comb begin
      next_acc = chargeAcc;
      accStep = 1'b0;
      accWrap = 1'b0;
      if (!shutdown && chargeUpTick && !chargeDownTick && prescCount >= prescMax) begin
         next_acc = chargeAcc + 16'h1;
         accStep = 1'b1;
         accWrap = (chargeAcc == ACC_FULL);
      end else if (!shutdown && chargeDownTick && !chargeUpTick && prescCount == 12'h0) begin
         next_acc = chargeAcc - 16'h1;
         accStep = 1'b1;
         accWrap = (chargeAcc == 16'h0);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         prescCount <= 12'h0;
      end else if (shutdown && !shutdownDly) begin
         prescCount <= 12'h0;
      end else if (fullRequest || accWrite) begin
         prescCount <= 12'h0;
      end else if (!shutdown && chargeUpTick && !chargeDownTick) begin
         prescCount <= (prescCount >= prescMax) ? 12'h0 : prescCount + 12'h1;
      end else if (!shutdown && chargeDownTick && !chargeUpTick) begin
         prescCount <= (prescCount == 12'h0) ? prescMax : prescCount - 12'h1;
      end
   end

   // Accumulator: a full-battery preset beats a host write and counting
   always_ff @(posedge clk) begin
      if (srst) begin
         chargeAcc <= ACC_RESET;
      end else if (fullRequest) begin
         chargeAcc <= ACC_FULL;
      end else if (accWrite) begin
         chargeAcc <= accWriteData;
      end else begin
         chargeAcc <= next_acc;
      end
   end

   // Sequencer timing; the limit depends on the conversion in progress
   always_comb begin
      case (seqState)
         SEQ_VOLT: seqLimit = 32'(VOLT_CONV_CYCLES_P - 1);
         SEQ_CURR: seqLimit = 32'(AUX_CONV_CYCLES_P - 1);
         SEQ_TEMP: seqLimit = 32'(AUX_CONV_CYCLES_P - 1);
         SEQ_NAP: seqLimit = 32'(SCAN_SLEEP_CYCLES_P - 1);
         default: seqLimit = 32'h0;
      endcase
   end

   assign convEnd = (seqState == SEQ_VOLT || seqState == SEQ_CURR || seqState == SEQ_TEMP)
      && seqCount == seqLimit;
   assign passEnd = (seqState == SEQ_TEMP) && seqCount == seqLimit;
   // Manual mode clears itself only if the host is not writing the control register in the pass-end cycle
   assign modeClear = passEnd && adcMode == ADC_MANUAL && !ctrlWrite;

   // The mode field is looked at only between passes, so a rewrite
   // during a pass cannot cut it short
   always_ff @(posedge clk) begin
      if (srst) begin
         seqState <= SEQ_IDLE;
         seqCount <= 32'h0;
      end else begin
         case (seqState)
            SEQ_IDLE: begin
               seqCount <= 32'h0;
               if (adcMode != ADC_SLEEP && !shutdown) begin
                  seqState <= SEQ_VOLT;
               end
            end
            SEQ_VOLT: begin
               if (seqCount == seqLimit) begin
                  seqState <= SEQ_CURR;
                  seqCount <= 32'h0;
               end else begin
                  seqCount <= seqCount + 32'h1;
               end
            end
            SEQ_CURR: begin
               if (seqCount == seqLimit) begin
                  seqState <= SEQ_TEMP;
                  seqCount <= 32'h0;
               end else begin
                  seqCount <= seqCount + 32'h1;
               end
            end
            SEQ_TEMP: begin
               if (seqCount == seqLimit) begin
                  seqCount <= 32'h0;
                  if (adcMode == ADC_AUTO && !shutdown) begin
                     seqState <= SEQ_VOLT;
                  end else if (adcMode == ADC_SCAN) begin
                     seqState <= SEQ_NAP;
                  end else begin
                     seqState <= SEQ_IDLE;
                  end
               end else begin
                  seqCount <= seqCount + 32'h1;
               end
            end
            SEQ_NAP: begin
               if (adcMode != ADC_SCAN) begin
                  seqState <= SEQ_IDLE;
                  seqCount <= 32'h0;
               end else if (seqCount == seqLimit) begin
                  seqState <= shutdown ? SEQ_IDLE : SEQ_VOLT;
                  seqCount <= 32'h0;
               end else begin
                  seqCount <= seqCount + 32'h1;
               end
            end
            default: begin
               seqState <= SEQ_IDLE;
               seqCount <= 32'h0;
            end
         endcase
      end
   end

   // Converter status outputs, one result strobe per conversion end
   always_ff @(posedge clk) begin
      if (srst) begin
         adcBusy <= 1'b0;
         adcChannel <= CH_VOLT;
         resultStore <= 1'b0;
      end else begin
         // No gap between conversions of one pass, so busy rises once per pass; in mode 11 it stays high from pass to pass
         adcBusy <= (seqState == SEQ_VOLT || seqState == SEQ_CURR
            || seqState == SEQ_TEMP);
         resultStore <= convEnd;
         if (convEnd) begin
            adcChannel <= (seqState == SEQ_VOLT) ? CH_VOLT
               : (seqState == SEQ_CURR) ? CH_CURR : CH_TEMP;
         end
      end
   end

   // Flag events of this cycle at their fixed positions
   always_comb begin
      statusSet = 8'h0;
      statusSet[ST_UNDERVOLTAGE_LOCKOUT] = undervoltageLockout;
      statusSet[ST_VOLT] = convEnd && seqState == SEQ_VOLT && convOutOfRange;
      statusSet[ST_CURR] = convEnd && seqState == SEQ_CURR && convOutOfRange;
      statusSet[ST_TEMP] = convEnd && seqState == SEQ_TEMP && convOutOfRange;
      statusSet[ST_ACC_WRAP] = accWrap;
      statusSet[ST_CHARGE_HIGH] = accStep && next_acc > chargeThreshHigh;
      statusSet[ST_CHARGE_LOW] = accStep && next_acc < chargeThreshLow;
   end

   assign alertEvent = |statusSet[ST_CURR:ST_VOLT];

   // Clear on read; an event in the same cycle as the read survives
   always_ff @(posedge clk) begin
      if (srst) begin
         status <= STATUS_RESET;
      end else if (statusRead) begin
         status <= statusSet;
      end else begin
         status <= status | statusSet;
      end
   end

   // Open-drain alert: output level is fixed low, only the enable moves.
   // Once pulled, a config change cannot release it; only the response can.
   always_ff @(posedge clk) begin
      if (srst) begin
         pinOe <= 1'b0;
         pinOut <= 1'b0;
      end else begin
         pinOut <= 1'b0;
         if (alertEvent && pinCfg == PIN_ALERT) begin
            pinOe <= 1'b1;
         end else if (alertResponseDone) begin
            pinOe <= 1'b0;
         end
      end
   end

endmodule // gas_gauge_control_sequencer

// *** pkg/gauge_pkg.sv ***
// Constants, field layout and state encodings of the gauge control sequencer.
// Assumes a single 200 MHz core clock; all times below are derived from it.
package gauge_pkg;

   localparam int CLK_MHZ = 200;

   // Control register layout and reset value
   localparam int SHUTDOWN_BIT = 0;
   localparam int PIN_CFG_LSB = 1;
   localparam int PRESC_LSB = 3;
   localparam int ADC_MODE_LSB = 6;
   localparam logic [7:0] CONTROL_RESET = 8'h3c;

   // Status register layout and reset value
   localparam int ST_UNDERVOLTAGE_LOCKOUT = 0;
   localparam int ST_VOLT = 1;
   localparam int ST_CHARGE_LOW = 2;
   localparam int ST_CHARGE_HIGH = 3;
   localparam int ST_TEMP = 4;
   localparam int ST_ACC_WRAP = 5;
   localparam int ST_CURR = 6;
   localparam logic [7:0] STATUS_RESET = 8'h01;

   // Charge accumulator values and top prescaler code
   localparam logic [15:0] ACC_RESET = 16'h7fff;
   localparam logic [15:0] ACC_FULL = 16'hffff;
   localparam logic [2:0] PRESC_CODE_MAX = 3'h6;

   // Conversion and sleep times, nominal figures
   localparam int VOLT_CONV_US = 33000;
   localparam int AUX_CONV_US = 4500;
   localparam int SCAN_SLEEP_MS = 10000;
   localparam int VOLT_CONV_CYCLES = VOLT_CONV_US * CLK_MHZ;
   localparam int AUX_CONV_CYCLES = AUX_CONV_US * CLK_MHZ;
   localparam int SCAN_SLEEP_CYCLES = SCAN_SLEEP_MS * 1000 * CLK_MHZ;

   typedef enum logic [1:0] {
      PIN_OFF = 2'b00,
      PIN_FULL_IN = 2'b01,
      PIN_ALERT = 2'b10,
      PIN_BAD = 2'b11
   } pin_cfg_t;

   typedef enum logic [1:0] {
      ADC_SLEEP = 2'b00,
      ADC_MANUAL = 2'b01,
      ADC_SCAN = 2'b10,
      ADC_AUTO = 2'b11
   } adc_mode_t;

   typedef enum logic [1:0] {
      CH_VOLT = 2'b00,
      CH_CURR = 2'b01,
      CH_TEMP = 2'b10
   } chan_t;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b000,
      SEQ_VOLT = 3'b001,
      SEQ_CURR = 3'b010,
      SEQ_TEMP = 3'b011,
      SEQ_NAP = 3'b100
   } seq_t;

endpackage

// *** testbench/gauge_checker.sv ***
// Port-level assertions of the gauge control sequencer.
// Assumes the bind hands on the shortened conversion counts.
`timescale 1ns/1ps
module gauge_checker
   import gauge_pkg::*;
#(
   parameter int VOLT_CONV_CYCLES_P = 20,
   parameter int AUX_CONV_CYCLES_P = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ctrlWrite,
   input wire logic accWrite,
   input wire logic [7:0] control,
   input wire logic [7:0] status,
   input wire logic [15:0] chargeAcc,
   input wire logic alertResponseDone,
   input wire logic adcBusy,
   input wire logic [1:0] adcChannel,
   input wire logic resultStore,
   input wire logic analogEnable,
   input wire logic pinIn,
   input wire logic pinOut,
   input wire logic pinOe
);
   localparam int AUX_LO = AUX_CONV_CYCLES_P - 1;
   localparam int AUX_HI = AUX_CONV_CYCLES_P + 2;
   localparam int VOLT_LO = VOLT_CONV_CYCLES_P - 2;
   localparam int VOLT_HI = VOLT_CONV_CYCLES_P + 2;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence stored(logic [1:0] ch);
      resultStore && adcChannel == ch;
   endsequence
   sequence selfClear;
      control[7:6] == 2'b01 && !ctrlWrite ##1 control[7:6] == 2'b00;
   endsequence
   shut_analog_a: assert property (control[0] |=> !analogEnable)
      else $error("analog section on in shutdown");
   no_count_a: assert property (control[0] && !analogEnable && !accWrite
      && control[2:1] != 2'b01 |=> $stable(chargeAcc)) else $error("count moved in shutdown");
   alert_cause_a: assert property ($rose(pinOe) |-> $past(control[2:1]) == 2'b10)
      else $error("alert raised outside alert mode");
   alert_hold_a: assert property (pinOe && !alertResponseDone |=> pinOe)
      else $error("alert released without response");
   alert_release_a: assert property ($fell(pinOe) |-> $past(alertResponseDone))
      else $error("alert dropped without response");
   pin_quiet_a: assert property (control[2:1] != 2'b10 && !pinOe |=> !pinOe)
      else $error("pin driven while not in alert mode");
   drain_only_a: assert property (pinOe |-> !pinOut)
      else $error("pin driven high");
   full_preset_a: assert property ((control[2:1] == 2'b01 && !pinIn) [*3]
      |=> chargeAcc == 16'hffff) else $error("full input did not preset count");
   wrap_flag_a: assert property (((chargeAcc == 16'h0000 && $past(chargeAcc) == 16'hffff)
      || (chargeAcc == 16'hffff && $past(chargeAcc) == 16'h0000))
      && !$past(accWrite) && $past(control[2:1]) != 2'b01 |-> status[ST_ACC_WRAP])
      else $error("wrap without flag");
   volt_time_a: assert property ($rose(adcBusy) |-> ##[VOLT_LO:VOLT_HI] stored(CH_VOLT))
      else $error("voltage conversion time wrong");
   conv_order_a: assert property (stored(CH_VOLT) |-> ##[AUX_LO:AUX_HI] stored(CH_CURR)
      ##[AUX_LO:AUX_HI] stored(CH_TEMP)) else $error("pass order or timing wrong");
   self_clear_a: assert property (selfClear |-> ##[0:1] adcChannel == CH_TEMP)
      else $error("manual mode cleared before pass end");
endmodule // gauge_checker
bind gas_gauge_control_sequencer gauge_checker #(.VOLT_CONV_CYCLES_P(VOLT_CONV_CYCLES_P),
   .AUX_CONV_CYCLES_P(AUX_CONV_CYCLES_P)) chk_u (.clk(clk), .srst(srst), .ctrlWrite(ctrlWrite),
   .accWrite(accWrite), .control(control), .status(status), .chargeAcc(chargeAcc),
   .alertResponseDone(alertResponseDone), .adcBusy(adcBusy), .adcChannel(adcChannel),
   .resultStore(resultStore), .analogEnable(analogEnable), .pinIn(pinIn), .pinOut(pinOut),
   .pinOe(pinOe));

// *** testbench/gauge_host_model.sv ***
// Host side of the shared pin: pull-up, charger switch, alert response.
// Assumes the bench sets the response delay; zero keeps the host silent.
`timescale 1ns/1ps
module gauge_host_model (
   input wire logic clk,
   input wire logic pinOe,
   input wire logic chargerLow,
   input wire logic [7:0] ackDelay,
   output logic pinIn,
   output logic alertResponseDone
);
   logic [7:0] lowCount = 8'h00;
   // Wired line: the pull-up wins unless someone sinks it
   assign pinIn = !(pinOe || chargerLow);
   initial alertResponseDone = 1'b0;
   always @(posedge clk) begin
      alertResponseDone <= 1'b0;
      if (pinIn || ackDelay == 8'h00) begin
         lowCount <= 8'h00;
      end else if (lowCount == ackDelay) begin
         alertResponseDone <= 1'b1;
         lowCount <= 8'h00;
      end else begin
         lowCount <= lowCount + 8'h01;
      end
   end
endmodule // gauge_host_model

// *** testbench/gas_gauge_control_sequencer_bench.sv ***
// Self-checking bench of the gauge control sequencer with a host model.
// Assumes shortened conversion counts; the charger moves on a slow link clock.
`timescale 1ns/1ps
module gas_gauge_control_sequencer_bench;
   import gauge_pkg::*;
   localparam int VOLT_P = 20;
   localparam int AUX_P = 8;
   localparam int NAP_P = 30;
   logic clk = 1'b0, linkClk = 1'b0, srst = 1'b1, ctrlWrite = 1'b0, statusRead = 1'b0;
   logic accWrite = 1'b0, chargeUpTick = 1'b0, chargeDownTick = 1'b0, chargerReq = 1'b0;
   logic undervoltageLockout = 1'b0, convOutOfRange = 1'b1, chargerLow = 1'b0;
   logic [7:0] ctrlWriteData = 8'h00, ackDelay = 8'h00, control, status;
   logic [15:0] accWriteData = 16'h0000, chargeThreshHigh = 16'h1000, chargeAcc;
   logic [1:0] adcChannel, cq[$];
   logic adcBusy, resultStore, analogEnable, pinIn, pinOut, pinOe, alertResponseDone;
   int fails = 0, comparisons = 0, cycles = 0, tq[$];
   gas_gauge_control_sequencer #(.VOLT_CONV_CYCLES_P(VOLT_P), .AUX_CONV_CYCLES_P(AUX_P),
      .SCAN_SLEEP_CYCLES_P(NAP_P)) dut_u (.clk(clk), .srst(srst), .ctrlWrite(ctrlWrite),
      .ctrlWriteData(ctrlWriteData), .control(control), .statusRead(statusRead),
      .status(status), .accWrite(accWrite), .accWriteData(accWriteData), .chargeAcc(chargeAcc),
      .chargeThreshHigh(chargeThreshHigh), .chargeThreshLow(16'h0000),
      .chargeUpTick(chargeUpTick), .chargeDownTick(chargeDownTick),
      .undervoltageLockout(undervoltageLockout), .alertResponseDone(alertResponseDone),
      .convOutOfRange(convOutOfRange), .adcBusy(adcBusy), .adcChannel(adcChannel),
      .resultStore(resultStore), .analogEnable(analogEnable), .pinIn(pinIn),
      .pinOut(pinOut), .pinOe(pinOe));
   gauge_host_model host_u (.clk(clk), .pinOe(pinOe), .chargerLow(chargerLow),
      .ackDelay(ackDelay), .pinIn(pinIn), .alertResponseDone(alertResponseDone));
   always #2.5 clk = ~clk;
   // Offset start keeps charger edges away from core edges
   initial begin
      #1.3;
      forever #62.5 linkClk = ~linkClk;
   end
   always @(posedge linkClk) chargerLow <= chargerReq;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         fails++;
         stop_test();
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   function logic [15:0] inRange(input int g, input int lo, input int hi);
      return {15'h0000, g >= lo && g <= hi};
   endfunction
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wrCtrl(input logic [7:0] d);
      @(posedge clk);
      ctrlWrite <= 1'b1;
      ctrlWriteData <= d;
      @(posedge clk);
      ctrlWrite <= 1'b0;
      cyc(1);
   endtask
   task wrAcc(input logic [15:0] d);
      @(posedge clk);
      accWrite <= 1'b1;
      accWriteData <= d;
      @(posedge clk);
      accWrite <= 1'b0;
      cyc(1);
   endtask
   task rdStatus(input logic [7:0] exp);
      @(posedge clk);
      statusRead <= 1'b1;
      #1 check(status, exp);
      @(posedge clk);
      statusRead <= 1'b0;
      cyc(1);
   endtask
   task tick(input logic up, input int n);
      repeat (n) begin
         @(posedge clk);
         chargeUpTick <= up;
         chargeDownTick <= !up;
         @(posedge clk);
         chargeUpTick <= 1'b0;
         chargeDownTick <= 1'b0;
      end
      cyc(2);
   endtask
   task watch(input int n);
      tq.delete();
      cq.delete();
      for (int i = 0; i < n; i++) begin
         cyc(1);
         if (resultStore === 1'b1) begin
            tq.push_back(i);
            cq.push_back(adcChannel);
         end
      end
   endtask
   task done(input string s);
      $display("test %s finished", s);
   endtask
   task stop_test;
      $display("comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      int m;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      cyc(1);
      check(control, 8'h3c);
      check({status, chargeAcc}, 24'h017fff);
      check({adcBusy, pinOe}, 2'b00);
      @(posedge clk);
      undervoltageLockout <= 1'b1;
      @(posedge clk);
      undervoltageLockout <= 1'b0;
      rdStatus(8'h01);
      check({status, pinOe}, 9'h000);
      done("reset");
      for (int code = 0; code < 8; code++) begin
         m = (code == 7) ? 4096 : (1 << (2 * code));
         wrCtrl({2'b00, code[2:0], 3'b000});
         wrAcc(16'h1000);
         tick(1'b1, m - 1);
         check(chargeAcc, 16'h1000);
         tick(1'b1, 1);
         check(chargeAcc, 16'h1001);
      end
      rdStatus(8'h08);
      chargeThreshHigh <= 16'hffff;
      done("prescaler");
      wrCtrl(8'h08);
      wrAcc(16'h1000);
      tick(1'b1, 2);
      wrCtrl(8'h09);
      check({control, 7'h00, analogEnable}, 16'h0900);
      tick(1'b1, 5);
      check(chargeAcc, 16'h1000);
      wrCtrl(8'h08);
      tick(1'b1, 2);
      check(chargeAcc, 16'h1000);
      tick(1'b1, 2);
      check(chargeAcc, 16'h1001);
      done("shutdown");
      wrCtrl(8'h04);
      wrAcc(16'hffff);
      tick(1'b1, 1);
      check({chargeAcc, pinOe}, 17'h00001);
      wrCtrl(8'h00);
      cyc(10);
      check({pinOe, pinOut}, 2'b10);
      rdStatus(8'h20);
      ackDelay <= 8'h03;
      cyc(8);
      check(pinOe, 1'b0);
      tick(1'b0, 1);
      check({chargeAcc, pinOe}, 17'h1fffe);
      rdStatus(8'h20);
      done("alert");
      wrAcc(16'h1234);
      chargerReq <= 1'b1;
      cyc(80);
      check(chargeAcc, 16'h1234);
      chargerReq <= 1'b0;
      cyc(80);
      wrCtrl(8'h02);
      chargerReq <= 1'b1;
      cyc(80);
      check(chargeAcc, 16'hffff);
      chargerReq <= 1'b0;
      cyc(80);
      done("charge complete");
      wrCtrl(8'h44);
      watch(80);
      check({cq[0], cq[1], cq[2], 8'(tq.size())}, 16'h0603);
      check(inRange(tq[2] - tq[1], AUX_P - 1, AUX_P + 1), 16'h0001);
      check(control, 8'h04);
      rdStatus(8'h52);
      convOutOfRange <= 1'b0;
      wrCtrl(8'hc4);
      watch(100);
      check({cq[2], cq[3]}, 4'h8);
      check(inRange(tq[3] - tq[2], VOLT_P - 1, VOLT_P + 3), 16'h0001);
      wrCtrl(8'h04);
      watch(100);
      check({cq[$], adcBusy}, 3'b100);
      wrCtrl(8'h84);
      watch(150);
      check(inRange(tq[3] - tq[2], VOLT_P + NAP_P - 1, VOLT_P + NAP_P + 4), 16'h0001);
      done("sequencer");
      stop_test();
   end
endmodule // gas_gauge_control_sequencer_bench
